// ===== src/tai_alarm_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Open-circuit comparator is sampled only when a conversion starts.
// - Remote 1 open fault sets bit 2 of first status at 0x02.
// - Remote 2 open fault sets bit 2 of second status at 0x23.
// - With pin in alert mode, an open flag pulls alert low.
// - During a remote fault, the last good reading is kept and returned.
// - Alert can be masked; primary fail-safe output never can.
// - Alert asserts if any temperature is above high or at/below low limit.
// - Alert releases after alert response read, cause gone, and status cleared.
// - Fail-safe asserts when any temperature exceeds its fail-safe limit.
// - Fail-safe releases on its own at limit minus hysteresis, all channels.
// - Fail-safe limits reset to 85 degrees.
// - Hysteresis resets to 10 and may be rewritten any time.
// - Shared pin acts as alert or as second fail-safe output.
// - Second fail-safe asserts above high limits and cannot be masked.
// - Second fail-safe releases with the same hysteresis as the first.
// - Alert response read at 0001100 is answered while alert is low.
module tai_alarm_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Conversion results from the measurement engine
  input tai_pkg::tai_result_t result,
  input wire logic convStart,
  // Open-circuit comparators from the pins
  input wire logic remote1OpenRaw,
  input wire logic remote2OpenRaw,
  // Limit and configuration values
  input tai_pkg::tai_limits_t limLocal,
  input tai_pkg::tai_limits_t limRem1,
  input tai_pkg::tai_limits_t limRem2,
  input wire logic limWrite,
  input wire logic [7:0] hystWrData,
  input wire logic hystWrite,
  input wire logic alertMask,
  input wire logic pinIsSecondFs,
  // Register read port
  input tai_pkg::tai_rdreq_t rdReq,
  output logic [7:0] rdData,
  output logic rdValid,
  // Alert response
  input wire logic araRead,
  output logic araAck,
  // Temperature readback
  output logic [7:0] tempLocal,
  output logic [7:0] tempRem1,
  output logic [7:0] tempRem2,
  // Pins, open-drain with enable low while driving low; then hysteresis readback
  output logic failsafe_alarm_n,
  output logic failsafeOe_n,
  output logic sharedPinOut,
  output logic sharedPinOe_n,
  output logic [7:0] hysteresis
);
  typedef struct packed {
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic [7:0] tLoc;
    logic [7:0] tR1;
    logic [7:0] tR2;
    logic remote1_open_flag;
    logic remote2_open_flag;
    logic [7:0] hyst;
    logic alertLatched;
    logic araServed;
    logic [7:0] rdData;
    logic rdValid;
    logic araAck;
    logic fsPin;
    logic sharedPin;
    logic update;
  } tai_top_st_t;

  tai_top_st_t st_q;
  tai_top_st_t st_d;
  logic r1OpenSync;
  logic r2OpenSync;
  logic [2:0] fsAlarm;
  logic [2:0] fs2Alarm;
  logic [7:0] curTemp [3];
  tai_pkg::tai_limits_t lim [3];
  logic [2:0] hiErr;
  logic [2:0] loErr;
  logic causeActive;
  logic alertDrive;

  function automatic logic overHigh(input logic [7:0] t, input tai_pkg::tai_limits_t l);
    overHigh = t > l.high;
  endfunction

  function automatic logic atLow(input logic [7:0] t, input tai_pkg::tai_limits_t l);
    atLow = t <= l.low;
  endfunction

  tai_sync u_sync_r1 (
    .mclk(mclk),
    .rstn(rstn),
    .din(remote1OpenRaw),
    .dout(r1OpenSync)
  );

  tai_sync u_sync_r2 (
    .mclk(mclk),
    .rstn(rstn),
    .din(remote2OpenRaw),
    .dout(r2OpenSync)
  );

  assign curTemp[0] = st_q.tLoc;
  assign curTemp[1] = st_q.tR1;
  assign curTemp[2] = st_q.tR2;
  assign lim[0] = limLocal;
  assign lim[1] = limRem1;
  assign lim[2] = limRem2;

  // Fail-safe and second fail-safe comparators, shared hysteresis
  for (genvar i = 0; i < 3; i++) begin : g_cmp
    tai_hyst_cmp u_fs (
      .mclk(mclk),
      .rstn(rstn),
      .update(st_q.update),
      .temp(curTemp[i]),
      .limit(lim[i].failsafe),
      .hyst(st_q.hyst),
      .alarm(fsAlarm[i])
    );
    tai_hyst_cmp u_fs2 (
      .mclk(mclk),
      .rstn(rstn),
      .update(st_q.update),
      .temp(curTemp[i]),
      .limit(lim[i].high),
      .hyst(st_q.hyst),
      .alarm(fs2Alarm[i])
    );
  end

  always_comb begin
    st_d = st_q;
    st_d.rdValid = 1'b0;
    st_d.araAck = 1'b0;
    // Re-evaluate limits after a new result or a limit/hysteresis write
    st_d.update = result.valid | limWrite | hystWrite;
    for (int i = 0; i < 3; i++) begin
      hiErr[i] = overHigh(curTemp[i], lim[i]);
      loErr[i] = atLow(curTemp[i], lim[i]);
    end
    // Conversion start samples the comparators
    if (convStart) begin
      st_d.remote1_open_flag = r1OpenSync;
      st_d.remote2_open_flag = r2OpenSync;
    end
    // Store results, holding last good value under a fault
    if (result.valid) begin
      case (result.chan)
        2'd0: st_d.tLoc = result.temp;
        2'd1: if (!st_q.remote1_open_flag) st_d.tR1 = result.temp;
        2'd2: if (!st_q.remote2_open_flag) st_d.tR2 = result.temp;
        default: st_d.tLoc = st_q.tLoc;
      endcase
    end
    if (hystWrite) begin
      st_d.hyst = hystWrData;
    end
    // Register reads, clear on read
    if (rdReq.rd) begin
      st_d.rdValid = 1'b1;
      case (rdReq.addr)
        tai_pkg::FIRST_STATUS_ADDR: begin
          st_d.rdData = st_q.stat1;
          st_d.stat1 = 8'h00;
        end
        tai_pkg::SECOND_STATUS_ADDR: begin
          st_d.rdData = st_q.stat2;
          st_d.stat2 = 8'h00;
        end
        default: st_d.rdData = 8'h00;
      endcase
    end
    // Sticky status set wins over clear
    if (hiErr[0]) st_d.stat1[tai_pkg::LOCAL_HIGH_BIT] = 1'b1;
    if (loErr[0]) st_d.stat1[tai_pkg::LOCAL_LOW_BIT] = 1'b1;
    if (fsAlarm[0]) st_d.stat1[tai_pkg::LOCAL_FS_BIT] = 1'b1;
    if (hiErr[1]) st_d.stat1[tai_pkg::HIGH_FLAG_BIT] = 1'b1;
    if (loErr[1]) st_d.stat1[tai_pkg::LOW_FLAG_BIT] = 1'b1;
    if (fsAlarm[1]) st_d.stat1[tai_pkg::FAILSAFE_FLAG_BIT] = 1'b1;
    if (st_q.remote1_open_flag) st_d.stat1[tai_pkg::OPEN_FLAG_BIT] = 1'b1;
    if (hiErr[2]) st_d.stat2[tai_pkg::HIGH_FLAG_BIT] = 1'b1;
    if (loErr[2]) st_d.stat2[tai_pkg::LOW_FLAG_BIT] = 1'b1;
    if (fsAlarm[2]) st_d.stat2[tai_pkg::FAILSAFE_FLAG_BIT] = 1'b1;
    if (st_q.remote2_open_flag) st_d.stat2[tai_pkg::OPEN_FLAG_BIT] = 1'b1;
    // Alert latch and service
    causeActive = (|hiErr) | (|loErr) | st_q.remote1_open_flag | st_q.remote2_open_flag;
    if (causeActive) begin
      st_d.alertLatched = 1'b1;
      st_d.araServed = 1'b0;
    end
    if (araRead && st_q.alertLatched && !alertMask && !pinIsSecondFs) begin
      st_d.araAck = 1'b1;
      st_d.araServed = 1'b1;
    end
    if (st_q.araServed && !causeActive && (st_q.stat1 == 8'h00) && (st_q.stat2 == 8'h00)) begin
      st_d.alertLatched = 1'b0;
      st_d.araServed = 1'b0;
    end
    alertDrive = st_q.alertLatched && !alertMask;
    st_d.fsPin = |fsAlarm;
    st_d.sharedPin = pinIsSecondFs ? (|fs2Alarm) : alertDrive;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.hyst <= tai_pkg::HYSTERESIS_RST;
      st_q.tLoc <= tai_pkg::TEMP_RST;
      st_q.tR1 <= tai_pkg::TEMP_RST;
      st_q.tR2 <= tai_pkg::TEMP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdData = st_q.rdData;
  assign rdValid = st_q.rdValid;
  assign araAck = st_q.araAck;
  assign tempLocal = st_q.tLoc;
  assign tempRem1 = st_q.tR1;
  assign tempRem2 = st_q.tR2;
  assign failsafe_alarm_n = 1'b0;
  assign failsafeOe_n = ~st_q.fsPin;
  assign sharedPinOut = 1'b0;
  assign sharedPinOe_n = ~st_q.sharedPin;
  assign hysteresis = st_q.hyst;
endmodule

// ===== inc/tai_pkg.sv
package tai_pkg;
  // Channel indices
  localparam int CH_LOCAL = 0;
  localparam int CH_REM1 = 1;
  localparam int CH_REM2 = 2;
  localparam int NUM_CH = 3;
  // Register offsets
  localparam logic [7:0] FIRST_STATUS_ADDR = 8'h02;
  localparam logic [7:0] SECOND_STATUS_ADDR = 8'h23;
  // Field positions
  localparam int OPEN_FLAG_BIT = 2;
  localparam int HIGH_FLAG_BIT = 4;
  localparam int LOW_FLAG_BIT = 3;
  localparam int FAILSAFE_FLAG_BIT = 1;
  localparam int LOCAL_HIGH_BIT = 6;
  localparam int LOCAL_LOW_BIT = 5;
  localparam int LOCAL_FS_BIT = 0;
  // Values after reset
  localparam logic [7:0] FAILSAFE_LIMIT_RST = 8'h55;
  localparam logic [7:0] HYSTERESIS_RST = 8'h0A;
  localparam logic [7:0] HIGH_LIMIT_RST = 8'h55;
  localparam logic [7:0] LOW_LIMIT_RST = 8'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  // Alert response address, seven bits
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] failsafe;
  } tai_limits_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [7:0] temp;
  } tai_result_t;

  typedef struct packed {
    logic rd;
    logic [7:0] addr;
  } tai_rdreq_t;
endpackage

// ===== src/tai_sync.sv
`timescale 1ns/100ps
module tai_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Level in and out
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } tai_sync_st_t;

  tai_sync_st_t state_q;
  tai_sync_st_t state_d;

  always_comb begin
    state_d.s1 = din;
    state_d.s2 = state_q.s1;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign dout = state_q.s2;
endmodule

// ===== src/tai_hyst_cmp.sv
`timescale 1ns/100ps
module tai_hyst_cmp (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Update strobe and operands
  input wire logic update,
  input wire logic [7:0] temp,
  input wire logic [7:0] limit,
  input wire logic [7:0] hyst,
  // Alarm level
  output logic alarm
);
  typedef struct packed {
    logic alarm;
  } tai_hyst_st_t;

  tai_hyst_st_t state_q;
  tai_hyst_st_t state_d;
  logic [8:0] release_lvl;

  always_comb begin
    release_lvl = {1'b0, limit} - {1'b0, hyst};
    state_d = state_q;
    if (update) begin
      if (temp > limit) begin
        state_d.alarm = 1'b1;
      end else if (release_lvl[8] || ({1'b0, temp} <= release_lvl)) begin
        state_d.alarm = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign alarm = state_q.alarm;
endmodule

// ===== verification/tai_host_model.sv
`timescale 1ns/100ps
module tai_host_model (
  // Clock
  input wire logic mclk,
  // Answers
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  input wire logic araAck,
  // Requests
  output tai_pkg::tai_rdreq_t rdReq,
  output logic araRead
);
  initial begin
    rdReq = '0;
    araRead = 1'b0;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk) rdReq <= {1'b1, a};
    @(negedge mclk) begin
      d = rdValid ? rdData : 8'hXX;
      rdReq <= '0;
    end
  endtask
  // Alert response read
  task automatic ara(output logic ok);
    @(negedge mclk) araRead <= 1'b1;
    @(negedge mclk) begin
      ok = araAck;
      araRead <= 1'b0;
    end
  endtask
  // Alert service: response read, then both status reads
  task automatic service(output logic ok, output logic [7:0] s1, output logic [7:0] s2);
    ara(ok);
    rd(8'h02, s1);
    rd(8'h23, s2);
  endtask
endmodule

// ===== verification/tai_alarm_asserts.sv
`timescale 1ns/100ps
module tai_alarm_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Inputs
  input tai_pkg::tai_result_t result,
  input tai_pkg::tai_limits_t limLocal,
  input wire logic convStart,
  input wire logic remote1OpenRaw,
  input wire logic [7:0] hystWrData,
  input wire logic hystWrite,
  input wire logic alertMask,
  input wire logic pinIsSecondFs,
  input wire logic araRead,
  // Outputs
  input wire logic araAck,
  input wire logic [7:0] tempLocal,
  input wire logic failsafeOe_n,
  input wire logic sharedPinOe_n,
  input wire logic [7:0] hysteresis
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic alertMode, locHot;
  assign alertMode = !alertMask && !pinIsSecondFs;
  assign locHot = result.valid && result.chan == 2'h0;
  sequence s_open;
    remote1OpenRaw [*4] ##0 (convStart && alertMode);
  endsequence
  sequence s_held;
    !sharedPinOe_n [*4];
  endsequence
  a_fs_rise: assert property (
    locHot && result.temp > limLocal.failsafe |-> ##[1:4] !failsafeOe_n)
    else $error("fail-safe late");
  a_fs_release: assert property (
    $rose(failsafeOe_n) && $past(locHot, 3) |->
    {1'b0, $past(tempLocal, 2)} + hysteresis <= {1'b0, limLocal.failsafe})
    else $error("fail-safe released early");
  a_mask_alert: assert property (
    (alertMask && !pinIsSecondFs) [*4] |-> sharedPinOe_n)
    else $error("masked alert driven");
  a_open_alert: assert property (s_open |-> ##[1:5] !sharedPinOe_n)
    else $error("open flag gave no alert");
  a_high_hold: assert property (
    alertMode && locHot && result.temp > limLocal.high |-> ##4 s_held)
    else $error("alert not held");
  a_second_fs: assert property (
    pinIsSecondFs && locHot && result.temp > limLocal.high |-> ##[1:4] !sharedPinOe_n)
    else $error("second fail-safe late");
  a_ack_cause: assert property (
    araAck |-> $past(araRead) && !$past(alertMask) && !$past(pinIsSecondFs))
    else $error("unexpected response ack");
  a_hyst_write: assert property (
    hystWrite |-> ##[1:2] hysteresis == hystWrData)
    else $error("hysteresis not written");
endmodule
bind tai_alarm_top tai_alarm_asserts i_tai_alarm_asserts (.mclk, .rstn, .result, .limLocal,
  .convStart, .remote1OpenRaw, .hystWrData, .hystWrite, .alertMask, .pinIsSecondFs,
  .araRead, .araAck, .tempLocal, .failsafeOe_n, .sharedPinOe_n, .hysteresis);

// ===== verification/tai_alarm_top_bench.sv
`timescale 1ns/100ps
module tai_alarm_top_bench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  tai_pkg::tai_result_t result = '0;
  tai_pkg::tai_limits_t lim = {8'h40, 8'h10, tai_pkg::FAILSAFE_LIMIT_RST};
  tai_pkg::tai_rdreq_t rdReq;
  logic convStart = 1'b0;
  logic [1:0] openRaw = 2'h0;
  logic limWrite = 1'b0;
  logic [7:0] hystWrData = 8'h00;
  logic hystWrite = 1'b0;
  logic alertMask = 1'b0;
  logic pinIsSecondFs = 1'b0;
  logic araRead, rdValid, araAck, fsOe_n, shOe_n, ok;
  logic [7:0] rdData, tL, tR1, tR2, hyst, s1, s2, d, h;
  int err_total = 0;
  int comparisons = 0;
  int seed = 32'hED5A;
  always #2 mclk = ~mclk;
  tai_alarm_top i_tai_alarm_top (.mclk, .rstn, .result, .convStart,
    .remote1OpenRaw(openRaw[0]), .remote2OpenRaw(openRaw[1]), .limLocal(lim), .limRem1(lim),
    .limRem2(lim), .limWrite, .hystWrData, .hystWrite, .alertMask, .pinIsSecondFs, .rdReq,
    .rdData, .rdValid, .araRead, .araAck, .tempLocal(tL), .tempRem1(tR1), .tempRem2(tR2),
    .failsafe_alarm_n(), .failsafeOe_n(fsOe_n), .sharedPinOut(), .sharedPinOe_n(shOe_n),
    .hysteresis(hyst));
  tai_host_model i_tai_host_model (.mclk, .rdValid, .rdData, .araAck, .rdReq, .araRead);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pins(input logic f, input logic s);
    chk("fail-safe pin", {7'h00, f}, {7'h00, fsOe_n});
    chk("shared pin", {7'h00, s}, {7'h00, shOe_n});
  endtask
  task automatic conv(input logic [1:0] c, input logic [7:0] t);
    @(negedge mclk) result <= {1'b1, c, t};
    @(negedge mclk) result <= '0;
    repeat (6) @(negedge mclk);
  endtask
  task automatic pulse();
    @(negedge mclk) convStart <= 1'b1;
    @(negedge mclk) convStart <= 1'b0;
    repeat (6) @(negedge mclk);
  endtask
  task automatic setHyst(input logic [7:0] h);
    @(negedge mclk) hystWrData <= h;
    hystWrite <= 1'b1;
    @(negedge mclk) hystWrite <= 1'b0;
    @(negedge mclk) chk("hysteresis", h, hyst);
  endtask
  task automatic flush();
    repeat (2) begin
      i_tai_host_model.service(ok, s1, s2);
      repeat (6) @(negedge mclk);
    end
  endtask
  function automatic logic [7:0] expStat(int c, bit hi, bit second);
    if (second != (c == 2)) return 8'h00;
    return 8'h01 << (c == 0 ? (hi ? 6 : 5) : (hi ? 4 : 3));
  endfunction
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    summarize();
  end
  initial begin
    repeat (3) @(negedge mclk);
    rstn <= 1'b1;
    chk("hysteresis", tai_pkg::HYSTERESIS_RST, hyst);
    pins(1'b1, 1'b1);
    @(negedge mclk) limWrite <= 1'b1;
    @(negedge mclk) limWrite <= 1'b0;
    for (int c = 0; c < 3; c++) conv(2'(c), 8'h20);
    flush();
    for (int k = 0; k < 6; k++) begin
      conv(2'(k % 3), k < 3 ? 8'h41 : 8'h10);
      pins(1'b1, 1'b0);
      i_tai_host_model.service(ok, s1, s2);
      chk("ara ack", 8'h01, {7'h00, ok});
      chk("status1", expStat(k % 3, k < 3, 0), s1);
      chk("status2", expStat(k % 3, k < 3, 1), s2);
      repeat (6) @(negedge mclk);
      pins(1'b1, 1'b0);
      conv(2'(k % 3), 8'h20);
      flush();
      chk("status1 cleared", 8'h00, s1);
      pins(1'b1, 1'b1);
    end
    alertMask <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      h = 8'h01 + 8'($random(seed) & 31);
      setHyst(h);
      conv(2'(k % 3), 8'h56);
      pins(1'b0, 1'b1);
      conv(2'(k % 3), 8'h56 - h);
      pins(1'b0, 1'b1);
      conv(2'(k % 3), 8'h55 - h);
      pins(1'b1, 1'b1);
    end
    for (int c = 0; c < 3; c++) conv(2'(c), 8'h20);
    @(negedge mclk) pinIsSecondFs <= 1'b1;
    setHyst(8'h0A);
    conv(2'h0, 8'h41);
    pins(1'b1, 1'b0);
    i_tai_host_model.ara(ok);
    chk("ara ack", 8'h00, {7'h00, ok});
    conv(2'h0, 8'h37);
    pins(1'b1, 1'b0);
    conv(2'h0, 8'h36);
    pins(1'b1, 1'b1);
    @(negedge mclk) pinIsSecondFs <= 1'b0;
    alertMask <= 1'b0;
    flush();
    for (int r = 0; r < 2; r++) begin
      @(negedge mclk) openRaw[r] <= 1'b1;
      repeat (6) @(negedge mclk);
      pins(1'b1, 1'b1);
      pulse();
      pins(1'b1, 1'b0);
      conv(2'(r + 1), 8'h30);
      chk("remote temp", 8'h20, r ? tR2 : tR1);
      i_tai_host_model.rd(r ? 8'h23 : 8'h02, d);
      chk("open flag", 8'h04, d);
      @(negedge mclk) openRaw[r] <= 1'b0;
      repeat (4) @(negedge mclk);
      pulse();
      flush();
      pins(1'b1, 1'b1);
    end
    i_tai_host_model.rd(8'h40 | 8'($random(seed) & 63), d);
    chk("unmapped", 8'h00, d);
    summarize();
  end
endmodule
